// [rtl/pcfg_port.sv]
// GPIO port pin configuration: indirect subregisters and pad control
//
// Function
// [R1] Selector 02H reaches alternate function enable
// [R2] Enable 0: plain I/O, direction bit rules
// [R3] Enable 1: alternate function owns the pin
// [R4] Set1 and set2 bits pick one of four
// [R5] Enable resets 00H, port D 01H, small-A 04H
// [R6] Software enables only pins having alternate functions
// [R7] Selector 03H reaches open-drain control
// [R8] Open-drain bit 1 removes source current
// [R9] Open-drain acts even under alternate function
// [R10] Open-drain resets 00H, port D 01H
// [R11] Selector 04H reaches high drive enable
// [R12] High drive bit sets current, resets 0
// [R13] Selector 05H reaches wake source enable
// [R14] In stop, enabled pin edge starts recovery
// [R15] Selector 00H or 09H up reaches nothing
// [R16] Direction 0 drives data, 1 tristates, samples
// [R17] Per port: selector, control, four apart
// [R18] Control access touches only selected subregister
`timescale 1ns/1ns
module pcfg_port #(
  parameter logic [1:0] PORT_IDX  = 2'h0,
  parameter logic       SMALL_PKG = 1'b0
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rstn,
  // Register file access
  input  wire pcfg_pkg::pcfg_addr_t bus_addr,
  input  wire logic                 bus_wr,
  input  wire logic                 bus_rd,
  input  wire pcfg_pkg::pcfg_byte_t bus_wdata,
  output pcfg_pkg::pcfg_byte_t      bus_rdata,
  // Settings held by neighbouring registers
  input  wire pcfg_pkg::pcfg_byte_t port_direction_register,
  input  wire pcfg_pkg::pcfg_byte_t out_data,
  input  wire pcfg_pkg::pcfg_byte_t alt_set1,
  input  wire pcfg_pkg::pcfg_byte_t alt_set2,
  // Alternate function peripherals, 8 bits per function
  input  wire logic [31:0]          alt_out,
  input  wire logic [31:0]          alt_oe,
  // Pins and power state
  input  wire pcfg_pkg::pcfg_byte_t pin_in,
  input  wire logic                 stop_mode,
  // Pad controls, sampled pin levels and stop-mode wake request
  output pcfg_pkg::pcfg_byte_t      pad_out,
  output pcfg_pkg::pcfg_byte_t      pad_oe,
  output pcfg_pkg::pcfg_byte_t      pad_high_drive,
  output logic [15:0]               alt_select,
  output pcfg_pkg::pcfg_byte_t      in_data,
  output logic                      stop_wake_req
);
  import pcfg_pkg::*;

  // ------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------
  localparam pcfg_addr_t PORT_BASE = 12'(PCFG_BASE_ADDR + PCFG_PORT_STRIDE * {10'h000, PORT_IDX});
  localparam pcfg_addr_t SEL_ADDR  = 12'(PORT_BASE + PCFG_SEL_OFS);
  localparam pcfg_addr_t CTL_ADDR  = 12'(PORT_BASE + PCFG_CTL_OFS);

  logic                         hit_sel;
  logic                         hit_ctl;
  pcfg_byte_t                   selector;
  logic [PCFG_NUM_SUB-1:0]      sub_we;
  pcfg_byte_t [PCFG_NUM_SUB-1:0] sub_q;
  pcfg_byte_t                   af_en;
  pcfg_byte_t                   od_en;
  pcfg_byte_t                   hd_en;
  pcfg_byte_t                   wake_en;
  pcfg_byte_t                   next_rdata;

  assign hit_sel = (bus_addr == SEL_ADDR); // [R17]
  assign hit_ctl = (bus_addr == CTL_ADDR); // [R17]

  assign af_en   = sub_q[PCFG_SUB_AF];
  assign od_en   = sub_q[PCFG_SUB_OD];
  assign hd_en   = sub_q[PCFG_SUB_HD];
  assign wake_en = sub_q[PCFG_SUB_WAKE];

  // ------------------------------------------------------------
  // Subregister selector
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      selector <= PCFG_SEL_NONE;
    end else if (bus_wr && hit_sel) begin
      selector <= bus_wdata;
    end
  end

  // ------------------------------------------------------------
  // Subregister bank
  // ------------------------------------------------------------
  // Codes 00H and 09H-FFH match no entry, so a stray write is harmless
  generate
    for (genvar k = 0; k < PCFG_NUM_SUB; k++) begin : g_sub
      assign sub_we[k] = bus_wr && hit_ctl && (selector == PCFG_SUB_SEL[k]); // [R1] [R7] [R11] [R13] [R15] [R18]

      pcfg_subreg #(
        .RESET_VAL (pcfg_reset_val(k, PORT_IDX, SMALL_PKG)) // [R5] [R10] [R12]
      ) u_subreg (
        .clk   (clk),
        .rstn  (rstn),
        .wr_en (sub_we[k]),
        .wdata (bus_wdata),
        .q     (sub_q[k])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  // Codes held by neighbouring registers (direction, pull-up, sets) read 00H here
  always_comb begin
    next_rdata = PCFG_RST_ZERO;
    if (hit_sel) begin
      next_rdata = selector;
    end else if (hit_ctl) begin
      for (int k = 0; k < PCFG_NUM_SUB; k++) begin
        if (selector == PCFG_SUB_SEL[k]) begin
          next_rdata = sub_q[k]; // [R18]
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bus_rdata <= PCFG_RST_ZERO;
    end else if (bus_rd) begin
      bus_rdata <= next_rdata;
    end else begin
      bus_rdata <= PCFG_RST_ZERO;
    end
  end

  // ------------------------------------------------------------
  // Pad control
  // ------------------------------------------------------------
  // Enabling a pin with no function behind it picks whatever that slot
  // carries; software must avoid it [R6]
  pcfg_byte_t  next_pad_out;
  pcfg_byte_t  next_pad_oe;
  logic [15:0] next_alt_select;

  generate
    for (genvar i = 0; i < 8; i++) begin : g_pin
      logic [1:0] fsel;
      logic       drv_val;
      logic       drv_en;

      assign fsel = {alt_set2[i], alt_set1[i]}; // [R4]
      assign next_alt_select[2*i+1:2*i] = af_en[i] ? fsel : 2'h0;

      always_comb begin
        if (af_en[i]) begin
          drv_val = alt_out[{fsel, 3'(i)}]; // [R3]
          drv_en  = alt_oe[{fsel, 3'(i)}];  // [R3]
        end else begin
          drv_val = out_data[i];                   // [R16]
          drv_en  = !port_direction_register[i];   // [R2] [R16]
        end
      end

      // A high level is left to the pull-up in open-drain mode
      assign next_pad_out[i] = drv_val;
      assign next_pad_oe[i]  = drv_en && !(od_en[i] && drv_val); // [R8] [R9]
    end
  endgenerate

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pad_out    <= PCFG_RST_ZERO;
      pad_oe     <= PCFG_RST_ZERO;
      alt_select <= 16'h0000;
    end else begin
      pad_out    <= next_pad_out;
      pad_oe     <= next_pad_oe;
      alt_select <= next_alt_select;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pad_high_drive <= PCFG_RST_ZERO;
    end else begin
      pad_high_drive <= hd_en; // [R12]
    end
  end

  // Pins are sampled every cycle; only input pins carry meaning
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      in_data <= PCFG_RST_ZERO;
    end else begin
      in_data <= pin_in; // [R16]
    end
  end

  // ------------------------------------------------------------
  // Stop-mode wake
  // ------------------------------------------------------------
  pcfg_wake u_wake (
    .clk       (clk),
    .rstn      (rstn),
    .stop_mode (stop_mode),
    .pin_in    (pin_in),
    .wake_en   (wake_en),
    .wake_req  (stop_wake_req) // [R14]
  );

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_af_write;
    bus_wr && hit_ctl && selector == PCFG_SEL_AF |=> af_en == $past(bus_wdata);
  endproperty
  a_af_write: assert property (p_af_write) else $error("Alternate enable write missed"); // [R1]

  property p_od_write;
    bus_wr && hit_ctl && selector == PCFG_SEL_OD |=> od_en == $past(bus_wdata) && af_en == $past(af_en);
  endproperty
  a_od_write: assert property (p_od_write) else $error("Open-drain write missed or leaked"); // [R7]

  property p_hd_write;
    bus_wr && hit_ctl && selector == PCFG_SEL_HD |=> hd_en == $past(bus_wdata) ##1 pad_high_drive == $past(hd_en);
  endproperty
  a_hd_write: assert property (p_hd_write) else $error("High drive write not reflected"); // [R11] [R12]

  property p_wake_write;
    bus_wr && hit_ctl && selector == PCFG_SEL_WAKE |=> wake_en == $past(bus_wdata) && hd_en == $past(hd_en);
  endproperty
  a_wake_write: assert property (p_wake_write) else $error("Wake enable write missed"); // [R13]

  property p_no_target;
    bus_wr && hit_ctl && (selector == PCFG_SEL_NONE || selector >= PCFG_SEL_FIRST_FREE) |=> $stable(sub_q);
  endproperty
  a_no_target: assert property (p_no_target) else $error("Unmapped selector changed a subregister"); // [R15]

  property p_only_selected;
    bus_wr && hit_ctl && selector == PCFG_SEL_AF |=> $stable(od_en) && $stable(hd_en) && $stable(wake_en);
  endproperty
  a_only_selected: assert property (p_only_selected) else $error("Write touched an unselected subregister"); // [R18]

  property p_reset_vals;
    !$past(rstn) && !$past(bus_wr) |->
      af_en == pcfg_reset_val(PCFG_SUB_AF, PORT_IDX, SMALL_PKG) &&
      od_en == pcfg_reset_val(PCFG_SUB_OD, PORT_IDX, SMALL_PKG) && hd_en == 8'h00 && wake_en == 8'h00;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("Subregister reset value wrong"); // [R5] [R10]

  property p_gpio_input;
    af_en[0] == 1'b0 && port_direction_register[0] |=> pad_oe[0] == 1'b0;
  endproperty
  a_gpio_input: assert property (p_gpio_input) else $error("Input pin still driven"); // [R2] [R16]

  property p_gpio_output;
    af_en[0] == 1'b0 && !port_direction_register[0] && !od_en[0] |=> pad_oe[0] && pad_out[0] == $past(out_data[0]);
  endproperty
  a_gpio_output: assert property (p_gpio_output) else $error("Output pin not driving data"); // [R16]

  property p_alt_pin;
    af_en[1] |=> pad_out[1] == $past(alt_out[{alt_set2[1], alt_set1[1], 3'h1}]) &&
                alt_select[3:2] == $past({alt_set2[1], alt_set1[1]});
  endproperty
  a_alt_pin: assert property (p_alt_pin) else $error("Alternate function not driving pin"); // [R3] [R4]

  property p_open_drain;
    od_en[2] && next_pad_out[2] |=> pad_out[2] && !pad_oe[2];
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("Open-drain pin sourced a high level"); // [R8] [R9]

  property p_sel_readback;
    bus_rd && hit_sel |=> bus_rdata == $past(selector);
  endproperty
  a_sel_readback: assert property (p_sel_readback) else $error("Selector read back wrong"); // [R17]

  property p_ctl_readback;
    bus_rd && hit_ctl && selector == PCFG_SEL_OD |=> bus_rdata == $past(od_en);
  endproperty
  a_ctl_readback: assert property (p_ctl_readback) else $error("Open-drain read back wrong"); // [R7] [R18]

  property p_unmapped_read;
    bus_rd && hit_ctl && (selector == PCFG_SEL_NONE || selector >= PCFG_SEL_FIRST_FREE) |=> bus_rdata == 8'h00;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("Unmapped selector read not zero"); // [R15]

  property p_gpio_no_alt;
    !af_en[1] |=> alt_select[3:2] == 2'h0;
  endproperty
  a_gpio_no_alt: assert property (p_gpio_no_alt) else $error("Plain pin kept an alternate selection"); // [R2]

  property p_alt_oe;
    af_en[1] && !od_en[1] |=> pad_oe[1] == $past(alt_oe[{alt_set2[1], alt_set1[1], 3'h1}]);
  endproperty
  a_alt_oe: assert property (p_alt_oe) else $error("Alternate function not enabling pin"); // [R3]

  property p_od_alt;
    af_en[0] && od_en[0] && next_pad_out[0] |=> !pad_oe[0];
  endproperty
  a_od_alt: assert property (p_od_alt) else $error("Alternate output sourced a high level"); // [R9]

  property p_hd_alt;
    af_en[0] |=> pad_high_drive == $past(hd_en);
  endproperty
  a_hd_alt: assert property (p_hd_alt) else $error("High drive lost under alternate function"); // [R12]

  property p_in_sample;
    1'b1 |=> in_data == $past(pin_in);
  endproperty
  a_in_sample: assert property (p_in_sample) else $error("Pin level not sampled"); // [R16]

endmodule

// [include/pcfg_pkg.sv]
// Constants and types for the GPIO port pin configuration block
package pcfg_pkg;

  typedef logic [7:0]  pcfg_byte_t;
  typedef logic [11:0] pcfg_addr_t;

  // ------------------------------------------------------------
  // Register addresses
  // ------------------------------------------------------------
  localparam pcfg_addr_t PCFG_BASE_ADDR   = 12'hFD0;
  localparam pcfg_addr_t PCFG_PORT_STRIDE = 12'h004;
  localparam pcfg_addr_t PCFG_SEL_OFS     = 12'h000;
  localparam pcfg_addr_t PCFG_CTL_OFS     = 12'h001;

  // ------------------------------------------------------------
  // Subregister selector codes
  // ------------------------------------------------------------
  localparam pcfg_byte_t PCFG_SEL_NONE  = 8'h00;
  localparam pcfg_byte_t PCFG_SEL_DIR   = 8'h01;
  localparam pcfg_byte_t PCFG_SEL_AF    = 8'h02;
  localparam pcfg_byte_t PCFG_SEL_OD    = 8'h03;
  localparam pcfg_byte_t PCFG_SEL_HD    = 8'h04;
  localparam pcfg_byte_t PCFG_SEL_WAKE  = 8'h05;
  localparam pcfg_byte_t PCFG_SEL_FIRST_FREE = 8'h09;

  // Index of each held subregister in the bank
  localparam int PCFG_SUB_AF   = 0;
  localparam int PCFG_SUB_OD   = 1;
  localparam int PCFG_SUB_HD   = 2;
  localparam int PCFG_SUB_WAKE = 3;
  localparam int PCFG_NUM_SUB  = 4;

  localparam pcfg_byte_t PCFG_SUB_SEL [PCFG_NUM_SUB] = '{PCFG_SEL_AF, PCFG_SEL_OD, PCFG_SEL_HD, PCFG_SEL_WAKE};

  // ------------------------------------------------------------
  // Reset values and port identity
  // ------------------------------------------------------------
  localparam pcfg_byte_t PCFG_RST_ZERO    = 8'h00;
  localparam pcfg_byte_t PCFG_RST_PORT_D  = 8'h01;
  localparam pcfg_byte_t PCFG_RST_SMALL_A = 8'h04;
  localparam logic [1:0] PCFG_PORT_A      = 2'h0;
  localparam logic [1:0] PCFG_PORT_D      = 2'h3;

  // Reset value of one subregister for a given port and package
  function automatic pcfg_byte_t pcfg_reset_val(input int sub, input logic [1:0] port, input logic small_pkg);
    pcfg_byte_t v;
    v = PCFG_RST_ZERO;
    if (sub == PCFG_SUB_AF || sub == PCFG_SUB_OD) begin
      if (port == PCFG_PORT_D) begin
        v = PCFG_RST_PORT_D;
      end
    end
    if (sub == PCFG_SUB_AF && port == PCFG_PORT_A && small_pkg) begin
      v = PCFG_RST_SMALL_A;
    end
    return v;
  endfunction

endpackage

// [rtl/pcfg_subreg.sv]
// One 8-bit configuration subregister with a fixed reset value
`timescale 1ns/1ns
module pcfg_subreg #(
  parameter pcfg_pkg::pcfg_byte_t RESET_VAL = 8'h00
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rstn,
  // Write side
  input  wire logic                 wr_en,
  input  wire pcfg_pkg::pcfg_byte_t wdata,
  // Stored value
  output pcfg_pkg::pcfg_byte_t      q
);
  import pcfg_pkg::*;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= RESET_VAL;
    end else if (wr_en) begin
      q <= wdata;
    end
  end

endmodule

// [rtl/pcfg_wake.sv]
// Stop-mode wake detector: any edge on an enabled pin
`timescale 1ns/1ns
module pcfg_wake (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rstn,
  // Pins and enables
  input  wire logic                 stop_mode,
  input  wire pcfg_pkg::pcfg_byte_t pin_in,
  input  wire pcfg_pkg::pcfg_byte_t wake_en,
  // Recovery request
  output logic                      wake_req
);
  import pcfg_pkg::*;

  pcfg_byte_t prev_pin;
  pcfg_byte_t next_edge;

  assign next_edge = (pin_in ^ prev_pin) & wake_en;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prev_pin <= PCFG_RST_ZERO;
    end else begin
      prev_pin <= pin_in;
    end
  end

  // Held high while edges keep coming; recovery logic takes the first one
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wake_req <= 1'b0;
    end else begin
      wake_req <= stop_mode && (|next_edge); // [R14]
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_wake_edge;
    stop_mode && |((pin_in ^ prev_pin) & wake_en) |=> wake_req;
  endproperty
  a_wake_edge: assert property (p_wake_edge) else $error("Wake edge did not raise request"); // [R14]

  property p_wake_quiet;
    !stop_mode || ((pin_in ^ prev_pin) & wake_en) == 8'h00 |=> !wake_req;
  endproperty
  a_wake_quiet: assert property (p_wake_quiet) else $error("Wake request without enabled edge"); // [R14]

endmodule

// [sim/pcfg_pad_model.sv]
// Board-side model of the port pins: external drivers and pull-ups
`timescale 1ns/1ns
module pcfg_pad_model (
  // Pad side of the port
  input  wire pcfg_pkg::pcfg_byte_t pad_out,
  input  wire pcfg_pkg::pcfg_byte_t pad_oe,
  // External drivers on the board
  input  wire pcfg_pkg::pcfg_byte_t ext_val,
  input  wire pcfg_pkg::pcfg_byte_t ext_en,
  // Level seen on each pin
  output pcfg_pkg::pcfg_byte_t      pin_in
);
  import pcfg_pkg::*;
  // Pull-up on every pin: a released or open-drain pin with no external driver reads high, never stale
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad_oe[i]) pin_in[i] = pad_out[i];
      else if (ext_en[i]) pin_in[i] = ext_val[i];
      else pin_in[i] = 1'b1;
    end
  end
endmodule

// [sim/tb.sv]
// Self-checking testbench for the port pin configuration block
`timescale 1ns/1ns
module tb;
  import pcfg_pkg::*;
  localparam pcfg_addr_t SEL    = PCFG_BASE_ADDR + PCFG_PORT_STRIDE * 12'h003;
  localparam pcfg_addr_t CTL    = SEL + PCFG_CTL_OFS;
  localparam pcfg_byte_t PAT [4] = '{8'h3C, 8'h5A, 8'h96, 8'hC3};
  localparam logic [31:0] ALT_OUT = 32'h975A3DF0;
  localparam logic [31:0] ALT_OE  = 32'h0F0B070E;
  localparam pcfg_byte_t AF_ALT = 8'h0F;  // Only pins 0-3 have functions driven
  localparam pcfg_byte_t OD_ALT = 8'h01;

  logic        clk;
  logic        rstn;
  pcfg_addr_t  bus_addr;
  logic        bus_wr;
  logic        bus_rd;
  pcfg_byte_t  bus_wdata;
  pcfg_byte_t  bus_rdata;
  pcfg_byte_t  dir;
  pcfg_byte_t  out_data;
  pcfg_byte_t  alt_set1;
  pcfg_byte_t  alt_set2;
  logic [31:0] alt_out;
  logic [31:0] alt_oe;
  pcfg_byte_t  pin_in;
  logic        stop_mode;
  pcfg_byte_t  pad_out;
  pcfg_byte_t  pad_oe;
  pcfg_byte_t  pad_high_drive;
  logic [15:0] alt_select;
  pcfg_byte_t  in_data;
  logic        stop_wake_req;
  pcfg_byte_t  ext_val;
  pcfg_byte_t  ext_en;
  int          checks;
  int          fail_count;
  int          cycles;

  pcfg_port #(.PORT_IDX(PCFG_PORT_D), .SMALL_PKG(1'b0)) pcfg_port_i (
    .clk(clk), .rstn(rstn), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .port_direction_register(dir),
    .out_data(out_data), .alt_set1(alt_set1), .alt_set2(alt_set2), .alt_out(alt_out),
    .alt_oe(alt_oe), .pin_in(pin_in), .stop_mode(stop_mode), .pad_out(pad_out),
    .pad_oe(pad_oe), .pad_high_drive(pad_high_drive), .alt_select(alt_select),
    .in_data(in_data), .stop_wake_req(stop_wake_req));

  pcfg_pad_model pcfg_pad_model_i (
    .pad_out(pad_out), .pad_oe(pad_oe), .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d, mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic bus_write(input pcfg_addr_t a, input pcfg_byte_t d);
    @(posedge clk);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_wr    <= 1'b1;
    @(posedge clk);
    bus_wr    <= 1'b0;
  endtask

  // Read data is registered: look at it in the cycle after the read edge
  task automatic bus_read(input pcfg_addr_t a, output pcfg_byte_t d);
    @(posedge clk);
    bus_addr <= a;
    bus_rd   <= 1'b1;
    @(posedge clk);
    bus_rd   <= 1'b0;
    #1;
    d = bus_rdata;
  endtask

  task automatic sub_write(input pcfg_byte_t sel, input pcfg_byte_t d);
    bus_write(SEL, sel);
    bus_write(CTL, d);
  endtask

  task automatic sub_check(input pcfg_byte_t sel, input pcfg_byte_t exp);
    pcfg_byte_t d;
    bus_write(SEL, sel);
    bus_read(CTL, d);
    chk(d, exp);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    pcfg_byte_t d;
    bus_read(SEL, d);
    chk(d, PCFG_SEL_NONE);
    sub_check(PCFG_SEL_AF, 8'h01);
    sub_check(PCFG_SEL_OD, 8'h01);
    sub_check(PCFG_SEL_HD, 8'h00);
    sub_check(PCFG_SEL_WAKE, 8'h00);
  endtask

  task automatic t_isolation();
    pcfg_byte_t d;
    pcfg_byte_t bad [3] = '{PCFG_SEL_NONE, PCFG_SEL_FIRST_FREE, 8'hFF};
    for (int s = 0; s < PCFG_NUM_SUB; s++) sub_write(PCFG_SUB_SEL[s], PAT[s]);
    foreach (bad[k]) begin
      sub_write(bad[k], 8'hFF);
      bus_read(CTL, d);
      chk(d, 8'h00);
    end
    for (int s = 0; s < PCFG_NUM_SUB; s++) sub_check(PCFG_SUB_SEL[s], PAT[s]);
    // Another port's selector must not disturb this one
    bus_write(PCFG_BASE_ADDR, PCFG_SEL_AF);
    bus_read(SEL, d);
    chk(d, PCFG_SEL_WAKE);
  endtask

  task automatic t_gpio();
    sub_write(PCFG_SEL_AF, 8'h00);
    sub_write(PCFG_SEL_OD, 8'h1E);
    sub_write(PCFG_SEL_HD, 8'h81);
    @(posedge clk);
    dir      <= 8'hCC;
    out_data <= 8'h55;
    ext_en   <= 8'hCC;
    ext_val  <= 8'hA0;
    settle();
    chk(pad_out, 8'h55);
    chk(pad_oe, 8'h23);
    chk(pad_high_drive, 8'h81);
    chk(in_data, 8'h91);
  endtask

  task automatic t_alt();
    pcfg_byte_t v;
    pcfg_byte_t e;
    sub_write(PCFG_SEL_AF, AF_ALT);
    sub_write(PCFG_SEL_OD, OD_ALT);
    @(posedge clk);
    ext_en  <= 8'hC0;
    alt_out <= ALT_OUT;
    alt_oe  <= ALT_OE;
    for (int f = 0; f < 4; f++) begin
      @(posedge clk);
      alt_set1 <= {8{f[0]}};
      alt_set2 <= {8{f[1]}};
      settle();
      for (int i = 0; i < 8; i++) begin
        v[i] = AF_ALT[i] ? ALT_OUT[f*8+i] : out_data[i];
        e[i] = (AF_ALT[i] ? ALT_OE[f*8+i] : ~dir[i]) & ~(OD_ALT[i] & v[i]);
      end
      chk(pad_out, v);
      chk(pad_oe, e);
      chk(alt_select, {8'h00, {4{f[1:0]}}});
    end
    chk(pad_high_drive, 8'h81);
  endtask

  // Change the pins at one edge; any request shows in the next cycle only
  task automatic pulse_pin(input pcfg_byte_t val, input logic exp);
    @(posedge clk);
    ext_val <= val;
    @(posedge clk);
    #1;
    chk(stop_wake_req, exp);
    @(posedge clk);
    #1;
    chk(stop_wake_req, 1'b0);
  endtask

  task automatic t_wake();
    sub_write(PCFG_SEL_AF, 8'h00);
    sub_write(PCFG_SEL_WAKE, 8'h02);
    @(posedge clk);
    dir     <= 8'hFF;
    ext_en  <= 8'hFF;
    ext_val <= 8'h00;
    settle();
    pulse_pin(8'h02, 1'b0);
    @(posedge clk);
    stop_mode <= 1'b1;
    settle();
    pulse_pin(8'h00, 1'b1);
    pulse_pin(8'h01, 1'b0);
    pulse_pin(8'h03, 1'b1);
  endtask

  // ------------------------------------------------------------
  // Clock, reset, sequence and timeout
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      summarize();
    end
  end

  initial begin
    rstn      = 1'b0;
    bus_addr  = 12'h000;
    bus_wr    = 1'b0;
    bus_rd    = 1'b0;
    bus_wdata = 8'h00;
    dir       = 8'hFF;
    out_data  = 8'h00;
    alt_set1  = 8'h00;
    alt_set2  = 8'h00;
    alt_out   = 32'h00000000;
    alt_oe    = 32'h00000000;
    stop_mode = 1'b0;
    ext_val   = 8'h00;
    ext_en    = 8'h00;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_isolation();
    t_gpio();
    t_alt();
    t_wake();
    summarize();
  end
endmodule
